// >>> spa_pkg.sv
// Constants, register map and coefficient tables for the scaler prefilter and picture adjust
package spa_pkg;

	// ==========================================================
	// Register map: two identical settings sets
	localparam int              SPA_SET_SIZE    = 5;
	localparam int              SPA_IDX_LEN     = 0;
	localparam int              SPA_IDX_PF      = 1;
	localparam int              SPA_IDX_OFS     = 2;
	localparam int              SPA_IDX_YG      = 3;
	localparam int              SPA_IDX_CG      = 4;
	localparam logic [7:0]      SPA_ADDR_A [SPA_SET_SIZE] = '{8'hA1, 8'hA2, 8'hA4, 8'hA5, 8'hA6};
	localparam logic [7:0]      SPA_ADDR_B [SPA_SET_SIZE] = '{8'hD1, 8'hD2, 8'hD4, 8'hD5, 8'hD6};
	localparam logic [7:0]      SPA_RST    [SPA_SET_SIZE] = '{8'h00, 8'h00, 8'h80, 8'h40, 8'h40};

	// ==========================================================
	// Field positions
	localparam int              SPA_LEN_MSB     = 5;
	localparam int              SPA_PFC_MSB     = 7;
	localparam int              SPA_PFC_LSB     = 6;
	localparam int              SPA_PFY_MSB     = 5;
	localparam int              SPA_PFY_LSB     = 4;
	localparam int              SPA_WEIGHT_BIT  = 3;
	localparam int              SPA_RENORM_MSB  = 2;
	localparam int              SPA_GAIN_MSB    = 6;

	// ==========================================================
	// Arithmetic constants
	localparam logic [7:0]      SPA_NEUTRAL     = 8'h80;
	localparam logic [6:0]      SPA_UNITY       = 7'h40;
	localparam int              SPA_GAIN_SHIFT  = 6;
	localparam int              SPA_FIR_SHIFT   = 5;
	localparam logic signed [17:0] SPA_FIR_ROUND = 18'sh00010;
	localparam int              SPA_TAPS        = 7;

	// Coefficients in 1/32 units, index [mode][tap]
	localparam logic signed [7:0] SPA_COEF_Y [4][SPA_TAPS] = '{
		'{8'sh00, 8'sh00, 8'sh00, 8'sh20, 8'sh00, 8'sh00, 8'sh00},
		'{8'sh00, 8'sh00, 8'sh08, 8'sh10, 8'sh08, 8'sh00, 8'sh00},
		'{8'shFC, 8'sh04, 8'sh07, 8'sh12, 8'sh07, 8'sh04, 8'shFC},
		'{8'sh00, 8'sh04, 8'sh08, 8'sh08, 8'sh08, 8'sh04, 8'sh00}};
	localparam logic signed [7:0] SPA_COEF_C [4][SPA_TAPS] = '{
		'{8'sh00, 8'sh00, 8'sh00, 8'sh20, 8'sh00, 8'sh00, 8'sh00},
		'{8'sh00, 8'sh00, 8'sh08, 8'sh10, 8'sh08, 8'sh00, 8'sh00},
		'{8'sh00, 8'sh03, 8'sh08, 8'sh0A, 8'sh08, 8'sh03, 8'sh00},
		'{8'sh00, 8'sh04, 8'sh08, 8'sh08, 8'sh08, 8'sh04, 8'sh00}};

	// Saturate an accumulator value to eight bits
	function automatic logic [7:0] spa_sat8(input logic [14:0] v);
		spa_sat8 = (v > 15'h00FF) ? 8'hFF : v[7:0];
	endfunction : spa_sat8

endpackage : spa_pkg

// >>> spa_prefilter.sv
// Seven-tap selectable FIR prefilter for one sample component
`timescale 1ns/100ps
module spa_prefilter
	import spa_pkg::*;
#(
	parameter bit CHROMA = 1'b0
)
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       srst,
	// Sample in
	input  wire logic       in_valid,
	input  wire logic [1:0] mode,
	input  wire logic [7:0] in_data,
	// Sample out
	output logic            out_valid,
	output logic [7:0]      out_data
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [SPA_TAPS-1:0][7:0] tap;
		logic                     v;
		logic [7:0]               d;
	} spa_fir_state_type;

	spa_fir_state_type st_reg;
	spa_fir_state_type st_next;

	// Shift, weight and clip; the window centre tap is the bypass path
	always_comb
	begin
		logic [SPA_TAPS-1:0][7:0] nt;
		logic signed [17:0]       acc;
		logic signed [17:0]       rnd;
		logic signed [7:0]        c;
		nt      = {st_reg.tap[SPA_TAPS-2:0], in_data};
		acc     = '0;
		rnd     = '0;
		c       = '0;
		st_next = st_reg;
		for (int k = 0; k < SPA_TAPS; k++)
		begin
			c   = CHROMA ? SPA_COEF_C[mode][k] : SPA_COEF_Y[mode][k];
			acc = acc + 18'($signed({1'b0, nt[k]}) * c);
		end
		rnd       = (acc + SPA_FIR_ROUND) >>> SPA_FIR_SHIFT;
		st_next.v = in_valid;
		if (in_valid)
		begin
			st_next.tap = nt;
			// Negative lobes can undershoot, wide gains overshoot
			if (rnd < 0)
				st_next.d = 8'h00;
			else if (rnd > 18'sh000FF)
				st_next.d = 8'hFF;
			else
				st_next.d = rnd[7:0];
		end
		if (srst)
			st_next = '0;
	end

	// State register
	always_ff @(posedge mclk)
	begin
		st_reg <= st_next;
	end

	assign out_valid = st_reg.v;
	assign out_data  = st_reg.d;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	bypass_centre_a: assert property ((in_valid && mode == 2'h0) |=> out_valid && out_data == $past(st_reg.tap[2]))
		else $error("bypass did not pass the centre sample");

	// Three-tap mode reads taps 2 to 4, so five flat samples must be in the window
	sequence flat_s;
		(in_valid && in_data == 8'h40) [*4] ##1 (in_valid && in_data == 8'h40 && mode == 2'h1);
	endsequence
	flat_gain_a: assert property (flat_s |=> out_data == 8'h40)
		else $error("three-tap filter altered a flat level");

endmodule : spa_prefilter

// >>> spa_core.sv
// Prescaler accumulation, prefilters and brightness, contrast, saturation stage
`timescale 1ns/100ps
module spa_core
	import spa_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       srst,
	// Register port
	input  wire logic       reg_we,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	// Field task control
	input  wire logic       field_start,
	input  wire logic       task_set_b,
	// Decoded samples in
	input  wire logic       pix_valid,
	input  wire logic [7:0] luma_in,
	input  wire logic [7:0] chroma_in,
	// Adjusted samples out
	output logic            out_valid,
	output logic [7:0]      luma_out,
	output logic [7:0]      chroma_out
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [2*SPA_SET_SIZE-1:0][7:0] cfg;
		logic                           set_b;
		logic [5:0]                     cnt;
		logic [14:0]                    acc_y;
		logic [14:0]                    acc_c;
		logic                           pre_v;
		logic [7:0]                     pre_y;
		logic [7:0]                     pre_c;
		logic                           out_v;
		logic [7:0]                     out_y;
		logic [7:0]                     out_c;
		logic [7:0]                     rdata;
	} spa_state_type;

	spa_state_type st_reg;
	spa_state_type st_next;

	logic [7:0]  act [SPA_SET_SIZE];
	logic [5:0]  cur_len;
	logic        cur_weight;
	logic [2:0]  cur_renorm;
	logic [14:0] sum_y;
	logic [14:0] sum_c;
	logic        fy_v;
	logic [7:0]  fy;
	logic        fc_v;
	logic [7:0]  fc;

	// Settings of the set picked for the current field
	always_comb
	begin
		for (int k = 0; k < SPA_SET_SIZE; k++)
			act[k] = st_reg.set_b ? st_reg.cfg[k+SPA_SET_SIZE] : st_reg.cfg[k];
	end

	assign cur_len    = act[SPA_IDX_LEN][SPA_LEN_MSB:0];
	assign cur_weight = act[SPA_IDX_PF][SPA_WEIGHT_BIT];
	assign cur_renorm = act[SPA_IDX_PF][SPA_RENORM_MSB:0];

	// Running sums including the present sample; ends of a sequence weigh one
	always_comb
	begin
		logic dbl;
		dbl   = cur_weight && st_reg.cnt != 6'h00 && st_reg.cnt < cur_len;
		sum_y = (st_reg.cnt == 6'h00 ? 15'h0000 : st_reg.acc_y)
			+ (dbl ? {6'h00, luma_in, 1'b0} : {7'h00, luma_in});
		sum_c = (st_reg.cnt == 6'h00 ? 15'h0000 : st_reg.acc_c)
			+ (dbl ? {6'h00, chroma_in, 1'b0} : {7'h00, chroma_in});
	end

	// ==========================================================
	// Prefilters
	spa_prefilter #(.CHROMA(1'b0)) u_fir_y (
		.mclk      (mclk),
		.srst      (srst),
		.in_valid  (st_reg.pre_v),
		.mode      (act[SPA_IDX_PF][SPA_PFY_MSB:SPA_PFY_LSB]),
		.in_data   (st_reg.pre_y),
		.out_valid (fy_v),
		.out_data  (fy)
	);

	spa_prefilter #(.CHROMA(1'b1)) u_fir_c (
		.mclk      (mclk),
		.srst      (srst),
		.in_valid  (st_reg.pre_v),
		.mode      (act[SPA_IDX_PF][SPA_PFC_MSB:SPA_PFC_LSB]),
		.in_data   (st_reg.pre_c),
		.out_valid (fc_v),
		.out_data  (fc)
	);

	// ==========================================================
	// Next state: registers, accumulation, picture adjust
	always_comb
	begin
		logic [14:0]        prod_y;
		logic signed [10:0] val_y;
		logic signed [8:0]  cs;
		logic signed [16:0] prod_c;
		logic signed [16:0] val_c;
		prod_y  = '0;
		val_y   = '0;
		cs      = '0;
		prod_c  = '0;
		val_c   = '0;
		st_next = st_reg;

		// Register writes and registered read-back; unmapped reads give zero
		st_next.rdata = 8'h00;
		for (int k = 0; k < SPA_SET_SIZE; k++)
		begin
			if (reg_we && reg_addr == SPA_ADDR_A[k])
				st_next.cfg[k] = reg_wdata;
			if (reg_we && reg_addr == SPA_ADDR_B[k])
				st_next.cfg[k+SPA_SET_SIZE] = reg_wdata;
			if (reg_addr == SPA_ADDR_A[k])
				st_next.rdata = st_reg.cfg[k];
			if (reg_addr == SPA_ADDR_B[k])
				st_next.rdata = st_reg.cfg[k+SPA_SET_SIZE];
		end

		// Set choice only moves at a field boundary so a field never mixes sets
		if (field_start)
			st_next.set_b = task_set_b;

		// Accumulation; >= guards against a length shortened mid-sequence
		st_next.pre_v = 1'b0;
		if (pix_valid)
		begin
			if (st_reg.cnt >= cur_len)
			begin
				st_next.pre_v = 1'b1;
				st_next.pre_y = spa_sat8(sum_y >> cur_renorm);
				st_next.pre_c = spa_sat8(sum_c >> cur_renorm);
				st_next.cnt   = 6'h00;
				st_next.acc_y = 15'h0000;
				st_next.acc_c = 15'h0000;
			end
			else
			begin
				st_next.cnt   = st_reg.cnt + 6'h01;
				st_next.acc_y = sum_y;
				st_next.acc_c = sum_c;
			end
		end

		// Contrast then brightness as a signed offset from neutral
		prod_y = 15'(fy * act[SPA_IDX_YG][SPA_GAIN_MSB:0]);
		val_y  = $signed({2'b00, prod_y[14:SPA_GAIN_SHIFT]})
			+ $signed({3'b000, act[SPA_IDX_OFS]})
			- $signed({3'b000, SPA_NEUTRAL});
		// Saturation scales chroma about its zero level
		cs     = $signed({1'b0, fc}) - $signed({1'b0, SPA_NEUTRAL});
		prod_c = 17'(cs * $signed({1'b0, act[SPA_IDX_CG][SPA_GAIN_MSB:0]}));
		val_c  = (prod_c >>> SPA_GAIN_SHIFT) + $signed({9'h000, SPA_NEUTRAL});

		st_next.out_v = fy_v;
		if (fy_v)
		begin
			st_next.out_y = val_y < 0 ? 8'h00 : (val_y > 11'sh0FF ? 8'hFF : val_y[7:0]);
			st_next.out_c = val_c < 0 ? 8'h00 : (val_c > 17'sh000FF ? 8'hFF : val_c[7:0]);
		end

		// Synchronous reset to neutral settings
		if (srst)
		begin
			st_next = '0;
			for (int k = 0; k < SPA_SET_SIZE; k++)
			begin
				st_next.cfg[k]              = SPA_RST[k];
				st_next.cfg[k+SPA_SET_SIZE] = SPA_RST[k];
			end
		end
	end

	// State register
	always_ff @(posedge mclk)
	begin
		st_reg <= st_next;
	end

	assign reg_rdata  = st_reg.rdata;
	assign out_valid  = st_reg.out_v;
	assign luma_out   = st_reg.out_y;
	assign chroma_out = st_reg.out_c;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	seq_length_a: assert property (st_reg.pre_v |-> $past(pix_valid) && $past(st_reg.cnt) >= $past(cur_len))
		else $error("sequence closed at the wrong length");

	inner_weight_a: assert property ((pix_valid && cur_weight && st_reg.cnt != 6'h00
		&& st_reg.cnt < cur_len) |=> st_reg.acc_y == $past(st_reg.acc_y) + {6'h00, $past(luma_in), 1'b0})
		else $error("inner sample not weighted by two");

	renorm_div8_a: assert property ((pix_valid && st_reg.cnt >= cur_len && cur_renorm == 3'h3)
		|=> st_reg.pre_v && st_reg.pre_y == spa_sat8($past(sum_y) / 15'h0008))
		else $error("renormalization by eight wrong");

	zero_contrast_a: assert property ((fy_v && act[SPA_IDX_YG][6:0] == 7'h00) |=> out_valid
		&& luma_out == ($past(act[SPA_IDX_OFS]) >= 8'h80 ? $past(act[SPA_IDX_OFS]) - 8'h80 : 8'h00))
		else $error("brightness offset not relative to neutral");

	unity_contrast_a: assert property ((fy_v && act[SPA_IDX_YG][6:0] == 7'h40
		&& act[SPA_IDX_OFS] == 8'h80) |=> luma_out == $past(fy))
		else $error("unity contrast altered luma");

	unity_sat_a: assert property ((fy_v && act[SPA_IDX_CG][6:0] == 7'h40) |=> chroma_out == $past(fc))
		else $error("unity saturation altered chroma");

	zero_sat_a: assert property ((fy_v && act[SPA_IDX_CG][6:0] == 7'h00) |=> chroma_out == 8'h80)
		else $error("zero saturation not neutral chroma");

	// Read-back two edges on reflects the address held one edge after the write
	set_b_write_a: assert property ((reg_we && reg_addr == 8'hD6) |=> st_reg.cfg[9] == $past(reg_wdata)
		##1 (reg_rdata == $past(reg_wdata, 2) || $past(reg_addr) != 8'hD6))
		else $error("set B register not written");

	set_a_write_a: assert property ((reg_we && reg_addr == 8'hA1) |=> st_reg.cfg[0] == $past(reg_wdata))
		else $error("set A register not written");

	task_pick_a: assert property (field_start |=> st_reg.set_b == $past(task_set_b))
		else $error("field task did not pick the set");

endmodule : spa_core

// >>> spa_src.sv
// Decoded sample source that feeds the prefilter and picture adjust stage
`timescale 1ns/100ps
module spa_src
(
	// Clock
	input  wire logic mclk,
	// Samples out
	output logic       pix_valid,
	output logic [7:0] luma_in,
	output logic [7:0] chroma_in
);
	// ========
	// Start idle with defined lines
	initial
	begin
		pix_valid = 1'b0;
		luma_in   = 8'h00;
		chroma_in = 8'h00;
	end

	// One sample per call, launched just after the edge
	task automatic push(input logic [7:0] y, input logic [7:0] c);
		@(posedge mclk);
		pix_valid <= 1'b1;
		luma_in   <= y;
		chroma_in <= c;
	endtask : push

	// Idle lines flip, so stale data can never pose as a sample
	task automatic idle();
		@(posedge mclk);
		pix_valid <= 1'b0;
		luma_in   <= ~luma_in;
		chroma_in <= ~chroma_in;
	endtask : idle
endmodule : spa_src

// >>> testbench.sv
// Self-checking bench for the prefilter and picture adjust stage
`timescale 1ns/100ps
module testbench import spa_pkg::*;
;
	// ========
	// Signals
	logic       mclk, srst, reg_we, field_start, task_set_b;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       pix_valid, out_valid;
	logic [7:0] luma_in, chroma_in, luma_out, chroma_out;
	logic [7:0] seen_y [$];
	logic [7:0] seen_c [$];
	int         err_total, total_checks, out_cnt;

	spa_core uut (.mclk(mclk), .srst(srst), .reg_we(reg_we), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .field_start(field_start),
		.task_set_b(task_set_b), .pix_valid(pix_valid), .luma_in(luma_in),
		.chroma_in(chroma_in), .out_valid(out_valid), .luma_out(luma_out),
		.chroma_out(chroma_out));
	spa_src src (.mclk(mclk), .pix_valid(pix_valid), .luma_in(luma_in), .chroma_in(chroma_in));

	// 50 MHz clock
	always #10 mclk = ~mclk;

	// Collect every output sample; order matters for the impulse checks
	always @(posedge mclk)
		if (out_valid === 1'b1)
		begin
			seen_y.push_back(luma_out);
			seen_c.push_back(chroma_out);
			out_cnt++;
		end

	// ========
	// Helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic wait_outs(input int n);
		for (int i = 0; i < 300 && out_cnt < n; i++)
			@(posedge mclk);
		if (out_cnt < n)
		begin
			err_total++;
			$display("ERROR %0t: output timeout", $time);
			complete_run();
		end
	endtask : wait_outs

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_we <= 1'b0;
	endtask : reg_wr

	// Read data is registered: look one edge after the address lands
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		@(posedge mclk);
		#1;
		check(reg_rdata, exp);
	endtask : reg_rd

	task automatic program_set(input bit b, input logic [7:0] len, pf, ofs, yg, cg);
		logic [7:0] v [SPA_SET_SIZE];
		v = '{len, pf, ofs, yg, cg};
		for (int i = 0; i < SPA_SET_SIZE; i++)
			reg_wr(b ? SPA_ADDR_B[i] : SPA_ADDR_A[i], v[i]);
		@(posedge mclk);
		field_start <= 1'b1;
		task_set_b  <= b;
		@(posedge mclk);
		field_start <= 1'b0;
	endtask : program_set

	// Accumulate, renormalize and saturate one constant component
	function automatic int pre(input int v, input int n, input int w, input int code);
		int s;
		s = (w != 0 && n > 0) ? v * 2 * n : v * (n + 1);
		s = s >>> code;
		return (s > 255) ? 255 : s;
	endfunction : pre

	function automatic logic [7:0] clip(input int v);
		return (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : v[7:0];
	endfunction : clip

	// Eight constant sequences fill the filter window, so the last output is exact
	task automatic run_const(input bit b, input logic [7:0] len, pf, ofs, yg, cg, y, c);
		int k, p, gy, gc, o;
		gy = yg[6:0];
		gc = cg[6:0];
		o = ofs;
		program_set(b, len, pf, ofs, yg, cg);
		k = out_cnt + 8;
		for (int i = 0; i < 8 * (len[5:0] + 1); i++)
			src.push(y, c);
		src.idle();
		wait_outs(k);
		p = pre(y, len[5:0], pf[3], pf[2:0]);
		check(seen_y[k - 1], clip(((p * gy) >>> 6) + o - 128));
		p = pre(c, len[5:0], pf[3], pf[2:0]);
		check(seen_c[k - 1], clip((((p - 128) * gc) >>> 6) + 128));
	endtask : run_const

	// ========
	// Scenarios
	task automatic t_regs();
		for (int i = 0; i < SPA_SET_SIZE; i++)
		begin
			reg_rd(SPA_ADDR_A[i], SPA_RST[i]);
			reg_rd(SPA_ADDR_B[i], SPA_RST[i]);
		end
		reg_wr(8'hA5, 8'hC3);
		reg_wr(8'hD5, 8'h3C);
		reg_wr(8'hA3, 8'h55);
		reg_rd(8'hA5, 8'hC3);
		reg_rd(8'hD5, 8'h3C);
		reg_rd(8'hA3, 8'h00);
	endtask : t_regs

	// Impulse after a zero flush shows every tap of each filter choice
	task automatic t_filters();
		int cy [4][7] = '{'{0, 0, 0, 32, 0, 0, 0}, '{0, 0, 8, 16, 8, 0, 0},
			'{-4, 4, 7, 18, 7, 4, -4}, '{0, 4, 8, 8, 8, 4, 0}};
		int cc [4][7] = '{'{0, 0, 0, 32, 0, 0, 0}, '{0, 0, 8, 16, 8, 0, 0},
			'{0, 3, 8, 10, 8, 3, 0}, '{0, 4, 8, 8, 8, 4, 0}};
		int k;
		for (int m = 0; m < 4; m++)
		begin
			program_set(1'b0, 8'h00, {m[1:0], m[1:0], 4'h0}, 8'h80, 8'h40, 8'h40);
			k = out_cnt;
			for (int i = 0; i < 16; i++)
				src.push((i == 7) ? 8'h40 : 8'h00, (i == 7) ? 8'h40 : 8'h00);
			src.idle();
			wait_outs(k + 16);
			for (int t = 0; t < 7; t++)
			begin
				check(seen_y[k + 7 + t], clip(2 * cy[m][t]));
				check(seen_c[k + 7 + t], clip(2 * cc[m][t]));
			end
		end
	endtask : t_filters

	task automatic t_length();
		run_const(1'b0, 8'h03, 8'h02, 8'h80, 8'h40, 8'h40, 8'd50, 8'd100);
		run_const(1'b0, 8'h3F, 8'h06, 8'h80, 8'h40, 8'h40, 8'd64, 8'd128);
	endtask : t_length

	task automatic t_weight();
		run_const(1'b0, 8'h04, 8'h0B, 8'h80, 8'h40, 8'h40, 8'd30, 8'd200);
		run_const(1'b0, 8'h3F, 8'h0F, 8'h80, 8'h40, 8'h40, 8'd100, 8'd128);
		run_const(1'b0, 8'h01, 8'h00, 8'h80, 8'h40, 8'h40, 8'd200, 8'd10);
		run_const(1'b0, 8'h0F, 8'hEC, 8'h80, 8'h40, 8'h40, 8'd120, 8'd60);
		run_const(1'b0, 8'h1F, 8'h05, 8'h80, 8'h40, 8'h40, 8'd250, 8'd255);
	endtask : t_weight

	// Gain bit 7 set on purpose: it must be ignored
	task automatic t_adjust();
		run_const(1'b0, 8'h00, 8'h00, 8'hA0, 8'hE0, 8'h20, 8'd100, 8'd160);
		run_const(1'b0, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h7F, 8'd10, 8'd0);
		run_const(1'b0, 8'h00, 8'h00, 8'hFF, 8'h7F, 8'h7F, 8'd200, 8'd255);
		run_const(1'b0, 8'h00, 8'h00, 8'hC0, 8'h80, 8'h80, 8'd90, 8'd30);
	endtask : t_adjust

	// Set B, then set A again; the two differ so a wrong pick shows
	task automatic t_sets();
		run_const(1'b1, 8'h01, 8'h01, 8'h90, 8'h40, 8'h50, 8'd60, 8'd140);
		run_const(1'b0, 8'h00, 8'h50, 8'h80, 8'h40, 8'h40, 8'd64, 8'd99);
	endtask : t_sets

	// ========
	// Main sequence
	initial
	begin
		mclk = 1'b0;
		srst = 1'b1;
		reg_we = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		field_start = 1'b0;
		task_set_b = 1'b0;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		#1;
		check({7'h00, out_valid}, 8'h00);
		t_regs();
		t_filters();
		t_length();
		t_weight();
		t_adjust();
		t_sets();
		complete_run();
	end
endmodule : testbench
